// ==== lsms_defs.vh ====
`ifndef LSMS_DEFS_VH
`define LSMS_DEFS_VH
`define LSMS_FN_READ 8'h03
`define LSMS_FN_WRITE 8'h06
`define LSMS_REG_STATUS 16'h0001
`define LSMS_REG_STRENGTH 16'h0002
`define LSMS_REG_ADDR 16'h0004
`define LSMS_REG_BAUD 16'h0005
`define LSMS_RD_ADDR 16'h0003
`define LSMS_RD_BAUD 16'h0004
`define LSMS_ADDR_RESET 8'h01
`define LSMS_ADDR_MIN 8'h01
`define LSMS_ADDR_MAX 8'hfe
`define LSMS_BAUD_RESET 8'h07
`define LSMS_CNT_MIN 16'h0001
`define LSMS_CNT_MAX 16'h0005
`define LSMS_LOW_THRESH 16'd3900
`define LSMS_HIGH_THRESH 16'd4100
`define LSMS_CRC_INIT 16'hffff
`define LSMS_CRC_POLY 16'ha001
`define LSMS_REQ_LEN 4'd8
`define LSMS_LED_MS 100
`define LSMS_CLK_MHZ 125
`define LSMS_LED_CYCLES (`LSMS_LED_MS * 1000 * `LSMS_CLK_MHZ)
`endif

// ==== lsms_slave.v ====
`timescale 1ns/1ps
`include "lsms_defs.vh"
// Overview of operation
// - station address 1..254; only frames with matching first byte are acted on
// - function byte 0x03 means register read
// - read start address bytes 3-4, count bytes 5-6, high byte first
// - read count must be 1 to 5
// - frames end in CRC16 over preceding bytes, low byte then high byte
// - read reply is address, function, byte count, data high/low, CRC
// - level status register at 1 reads 0 for absent, 1 for present
// - status absent below 3900, present above 4100, else holds
// - write 0x06 to register 0x04, byte five zero, byte six new address
// - good address change flashes LED, replies from new address echoing it
// - write 0x06 to register 0x05 sets baud code, flashes LED, no reply
// - baud codes 05..0f except 0b select 2400 to 256000 baud
module lsms_slave #(
  parameter LED_CYCLES = `LSMS_LED_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  input wire ce,
  // received bytes from uart
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_frame_end,
  // transmit bytes to uart
  output reg tx_valid,
  output reg [7:0] tx_data,
  input wire tx_ready,
  // sensor, indicator and configuration
  input wire [15:0] signal_strength_value,
  output reg led,
  output reg [7:0] station_address,
  output reg [7:0] baud_rate_code
);
  localparam S_RX = 2'd0;
  localparam S_EXEC = 2'd1;
  localparam S_TX = 2'd2;
  localparam S_CRC = 2'd3;

  reg [1:0] state;
  reg [7:0] req [0:7];
  reg [3:0] rx_cnt;
  reg [15:0] rx_crc;
  reg [7:0] rsp [0:14];
  reg [3:0] rsp_len;
  reg [3:0] tx_idx;
  reg [15:0] tx_crc;
  reg [1:0] crc_phase;
  reg level;
  reg [31:0] led_cnt;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `LSMS_CRC_POLY) : (t >> 1);
      end
      crc_byte = t;
    end
  endfunction

  function [15:0] reg_read;
    input [15:0] a;
    begin
      case (a)
        `LSMS_REG_STATUS: reg_read = {15'h0000, level};
        `LSMS_REG_STRENGTH: reg_read = signal_strength_value;
        // read offsets sit one below the write targets of the same settings
        `LSMS_RD_ADDR: reg_read = {8'h00, station_address};
        `LSMS_RD_BAUD: reg_read = {8'h00, baud_rate_code};
        default: reg_read = 16'h0000;
      endcase
    end
  endfunction

  // one half of a readable register, high half when hi is set
  function [7:0] reg_byte;
    input [15:0] a;
    input hi;
    reg [15:0] w;
    begin
      w = reg_read(a);
      reg_byte = hi ? w[15:8] : w[7:0];
    end
  endfunction

  wire [15:0] start = {req[2], req[3]};
  wire [15:0] count = {req[4], req[5]};
  wire [15:0] wr_reg = {req[2], req[3]};
  wire crc_ok = (rx_crc == 16'h0000);
  wire addr_hit = (req[0] == station_address);
  wire new_addr_ok = (req[4] == 8'h00) && (req[5] >= `LSMS_ADDR_MIN) && (req[5] <= `LSMS_ADDR_MAX);
  wire baud_ok = (req[4] == 8'h00) && (req[5] >= 8'h05) && (req[5] <= 8'h0f) && (req[5] != 8'h0b);
  wire read_ok = (count >= `LSMS_CNT_MIN) && (count <= `LSMS_CNT_MAX);
  wire tx_take = tx_valid && tx_ready;
  integer k;

  always @(posedge clk) begin
    if (!rst_b) begin
      level <= 1'b0;
    end else if (ce) begin
      if (signal_strength_value < `LSMS_LOW_THRESH) begin
        level <= 1'b0;
      end else if (signal_strength_value > `LSMS_HIGH_THRESH) begin
        level <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state <= S_RX;
      rx_cnt <= 4'h0;
      rx_crc <= `LSMS_CRC_INIT;
      rsp_len <= 4'h0;
      tx_idx <= 4'h0;
      tx_crc <= `LSMS_CRC_INIT;
      crc_phase <= 2'd0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      station_address <= `LSMS_ADDR_RESET;
      baud_rate_code <= `LSMS_BAUD_RESET;
      led_cnt <= 32'h0;
      led <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        req[k] <= 8'h00;
      end
      for (k = 0; k < 15; k = k + 1) begin
        rsp[k] <= 8'h00;
      end
    end else if (ce) begin
      led <= (led_cnt != 32'h0);
      if (led_cnt != 32'h0) begin
        led_cnt <= led_cnt - 32'h1;
      end
      case (state)
        S_RX: begin
          if (rx_valid) begin
            if (rx_cnt < `LSMS_REQ_LEN) begin
              req[rx_cnt[2:0]] <= rx_data;
            end
            // count one past a full request so an overlong frame fails the length test
            if (rx_cnt <= `LSMS_REQ_LEN) begin
              rx_cnt <= rx_cnt + 4'h1;
            end
            rx_crc <= crc_byte(rx_crc, rx_data);
          end
          // frame boundary from line silence
          if (rx_frame_end) begin
            if (rx_cnt == `LSMS_REQ_LEN && crc_ok && addr_hit) begin
              state <= S_EXEC;
            end
            rx_cnt <= 4'h0;
            rx_crc <= `LSMS_CRC_INIT;
          end
        end
        S_EXEC: begin
          state <= S_RX;
          tx_idx <= 4'h0;
          tx_crc <= `LSMS_CRC_INIT;
          crc_phase <= 2'd0;
          if (req[1] == `LSMS_FN_READ && read_ok) begin
            rsp[0] <= station_address;
            rsp[1] <= `LSMS_FN_READ;
            rsp[2] <= {count[6:0], 1'b0};
            for (k = 0; k < 5; k = k + 1) begin
              rsp[3 + 2 * k] <= reg_byte(start + k[15:0], 1'b1);
              rsp[4 + 2 * k] <= reg_byte(start + k[15:0], 1'b0);
            end
            rsp_len <= 4'd3 + {count[2:0], 1'b0};
            state <= S_TX;
          end else if (req[1] == `LSMS_FN_WRITE && wr_reg == `LSMS_REG_ADDR) begin
            // reply echoes whichever address is in force afterwards
            rsp[0] <= new_addr_ok ? req[5] : station_address;
            rsp[1] <= `LSMS_FN_WRITE;
            rsp[2] <= 8'h02;
            rsp[3] <= 8'h00;
            rsp[4] <= new_addr_ok ? req[5] : station_address;
            rsp_len <= 4'd5;
            state <= S_TX;
            if (new_addr_ok) begin
              station_address <= req[5];
              led_cnt <= LED_CYCLES;
            end
          end else if (req[1] == `LSMS_FN_WRITE && wr_reg == `LSMS_REG_BAUD && baud_ok) begin
            baud_rate_code <= req[5];
            led_cnt <= LED_CYCLES;
          end
        end
        S_TX: begin
          if (!tx_valid || tx_take) begin
            if (tx_idx < rsp_len) begin
              tx_valid <= 1'b1;
              tx_data <= rsp[tx_idx];
              tx_crc <= crc_byte(tx_crc, rsp[tx_idx]);
              tx_idx <= tx_idx + 4'h1;
            end else begin
              tx_valid <= 1'b0;
              state <= S_CRC;
            end
          end
        end
        S_CRC: begin
          if (!tx_valid || tx_take) begin
            crc_phase <= crc_phase + 2'd1;
            if (crc_phase == 2'd0) begin
              tx_valid <= 1'b1;
              tx_data <= tx_crc[7:0];
            end else if (crc_phase == 2'd1) begin
              tx_valid <= 1'b1;
              tx_data <= tx_crc[15:8];
            end else begin
              tx_valid <= 1'b0;
              state <= S_RX;
            end
          end
        end
        default: state <= S_RX;
      endcase
    end
  end
endmodule

// ==== lsms_checker.sv ====
`timescale 1ns/1ps
module lsms_checker (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // link and indicator
  input wire rx_frame_end,
  input wire tx_valid,
  input wire tx_ready,
  input wire led,
  input wire [7:0] tx_data,
  // configuration
  input wire [7:0] station_address,
  input wire [7:0] baud_rate_code
);
  reg [7:0] age;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles since the last frame end, saturating so long idle never wraps
  always @(posedge clk) begin
    if (!rst_b) age <= 8'hff;
    else if (rx_frame_end) age <= 8'h00;
    else if (age != 8'hff) age <= age + 8'h01;
  end
  property p_adr; station_address != 8'h00 && station_address != 8'hff; endproperty
  a_adr: assert property (p_adr) else $error("addr range");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("tx dropped");
  property p_ask; $rose(tx_valid) |-> age < 8'h40; endproperty
  a_ask: assert property (p_ask) else $error("unasked tx");
  // first reply byte is on the wire when age reads 2
  property p_first; tx_valid && age == 8'h02 |-> tx_data == station_address; endproperty
  a_first: assert property (p_first) else $error("first byte");
  property p_baud; baud_rate_code inside {[8'h05:8'h0f]} && baud_rate_code != 8'h0b; endproperty
  a_baud: assert property (p_baud) else $error("baud code");
  property p_cfg; $changed(station_address) || $changed(baud_rate_code) |-> age <= 8'h02; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg change");
  property p_led; $rose(led) |-> age <= 8'h02; endproperty
  a_led: assert property (p_led) else $error("led cause");
  property p_ledw; $rose(led) |-> led [*8]; endproperty
  a_ledw: assert property (p_ledw) else $error("led width");
  cover property (tx_valid && tx_ready);
  cover property ($rose(led));
  cover property ($changed(baud_rate_code));
endmodule
bind lsms_slave lsms_checker chk (
  .clk(clk),
  .rst_b(rst_b),
  .rx_frame_end(rx_frame_end),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .led(led),
  .tx_data(tx_data),
  .station_address(station_address),
  .baud_rate_code(baud_rate_code)
);

// ==== lsms_host.sv ====
`timescale 1ns/1ps
module lsms_host (
  input wire clk, tx_valid,
  input wire [7:0] tx_data,
  output reg rx_valid, rx_frame_end, tx_ready,
  output reg [7:0] rx_data
);
  logic [7:0] got[$];
  initial {rx_valid, rx_frame_end, tx_ready, rx_data} = 11'h000;
  // stall every other cycle so the slave has to hold its byte
  always @(posedge clk) tx_ready <= #1 ~tx_ready;
  always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
  function automatic void add_crc(ref logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction
  task automatic send(input logic [47:0] f, input logic bad);
    logic [7:0] q[$];
    for (int i = 5; i >= 0; i--) q.push_back(f[8*i+:8]);
    add_crc(q);
    q[7] = q[7] ^ {8{bad}};
    foreach (q[i]) begin
      @(posedge clk) #1 rx_valid = 1'b1;
      rx_data = q[i];
      @(posedge clk) #1 rx_valid = 1'b0;
      rx_data = ~rx_data;
    end
    @(posedge clk) #1 rx_frame_end = 1'b1;
    @(posedge clk) #1 rx_frame_end = 1'b0;
  endtask
endmodule

// ==== lsms_slave_tb.sv ====
`timescale 1ns/1ps
module lsms_slave_tb;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg ce = 1'b1;
  reg [15:0] signal_strength_value = 16'h0000;
  wire rx_valid, rx_frame_end, tx_valid, tx_ready, led;
  wire [7:0] rx_data, tx_data, station_address, baud_rate_code;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int led_cyc = 0;
  always #4 clk = ~clk;
  // cycles with the indicator lit, so a flash is measured after the reply
  always @(posedge clk) if (led) led_cyc++;
  lsms_host h (
    .clk(clk),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end),
    .tx_ready(tx_ready),
    .rx_data(rx_data)
  );
  lsms_slave #(.LED_CYCLES(10)) dut (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_frame_end(rx_frame_end),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .signal_strength_value(signal_strength_value),
    .led(led),
    .station_address(station_address),
    .baud_rate_code(baud_rate_code)
  );
  task ck(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [47:0] f, input logic bad, input int n, input logic [55:0] r);
    logic [7:0] q[$];
    for (int i = n - 1; i >= 0; i--) q.push_back(r[8*i+:8]);
    if (n > 0) h.add_crc(q);
    h.got.delete();
    h.send(f, bad);
    for (int i = 0; i < 200 && h.got.size() < q.size(); i++) @(posedge clk);
    repeat (30) @(posedge clk);
    #1;
    ck(8'(h.got.size()), 8'(q.size()));
    foreach (q[i]) ck(h.got[i], q[i]);
  endtask
  task t_reset;
    @(posedge clk) #1 rst_b = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    ck(station_address, 8'h01);
    ck(baud_rate_code, 8'h07);
    $display("reset done");
  endtask
  task t_read;
    signal_strength_value = 16'h1068;
    xfer(48'h010300010002, 1'b0, 7, 56'h01030400011068);
    signal_strength_value = 16'h0fa0;
    xfer(48'h010300010002, 1'b0, 7, 56'h01030400010fa0);
    signal_strength_value = 16'h0f3b;
    xfer(48'h010300010002, 1'b0, 7, 56'h01030400000f3b);
    signal_strength_value = 16'h0fa0;
    xfer(48'h010300010001, 1'b0, 5, 56'h0103020000);
    $display("read done");
  endtask
  task t_refuse;
    xfer(48'h010300010002, 1'b1, 0, 56'h0);
    xfer(48'h050300010002, 1'b0, 0, 56'h0);
    xfer(48'h010300010006, 1'b0, 0, 56'h0);
    xfer(48'h010300010000, 1'b0, 0, 56'h0);
    xfer(48'h010400010002, 1'b0, 0, 56'h0);
    $display("refuse done");
  endtask
  task t_cfg;
    int l;
    l = led_cyc;
    xfer(48'h010600040002, 1'b0, 5, 56'h0206020002);
    ck(station_address, 8'h02);
    ck(8'(led_cyc - l), 8'd10);
    l = led_cyc;
    xfer(48'h020600040000, 1'b0, 5, 56'h0206020002);
    ck(station_address, 8'h02);
    ck(8'(led_cyc - l), 8'd0);
    xfer(48'h010300010002, 1'b0, 0, 56'h0);
    l = led_cyc;
    xfer(48'h020600050009, 1'b0, 0, 56'h0);
    ck(baud_rate_code, 8'h09);
    ck(8'(led_cyc - l), 8'd10);
    l = led_cyc;
    xfer(48'h02060005000b, 1'b0, 0, 56'h0);
    ck(baud_rate_code, 8'h09);
    ck(8'(led_cyc - l), 8'd0);
    // with the enable low the whole frame must pass unseen
    ce = 1'b0;
    xfer(48'h020600050005, 1'b0, 0, 56'h0);
    ce = 1'b1;
    ck(baud_rate_code, 8'h09);
    $display("config done");
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_reset;
    t_read;
    t_refuse;
    t_cfg;
    t_reset;
    close_out;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      $display("CHECK FAILED %0t timeout", $time);
      close_out;
    end
  end
endmodule
